/* File: ces_event_selector.sv */
// Summary of operation
// - Event 24h mask FFh counts every L2 request, code and data.
// - Event 26h bits 01h..08h select demand loads in I, S, E, M.
// - L1 demand misses and L1 prefetches both count as demand loads.
// - Event 26h mask 0Fh counts every demand data request.
// - Event 26h bits 10h..80h select prefetch loads in I, S, E, M.
// - Prefetch RFO to shared line is a miss; prefetch read is a hit.
// - Event 26h mask F0h counts every prefetch request.
// - Event 26h mask FFh counts every data request.
// - Event 27h bits 01h..08h select store RFOs in I, S, E, M.
// - Event 27h mask 0Eh counts store RFO hits in S, E or M.
// - Event 27h mask 0Fh counts every store RFO.
// - Store RFO events count demand requests only.
// - Event 27h bits 10h..80h select locked RFOs in I, S, E, M.
`timescale 1ns/1ns
module ces_event_selector #(
   parameter int LANES     = 2,
   parameter int CNT_WIDTH = 48
) (
   // Clock and reset
   input  wire logic                   ref_clk_i,
   input  wire logic                   rst_i,
   // Counter configuration
   input  wire logic [7:0]             event_sel_i,
   input  wire logic [7:0]             unit_mask_i,
   input  wire logic                   count_en_i,
   // Request pipeline, one lane per request per cycle
   input  wire logic [LANES-1:0]       req_valid_i,
   input  wire ces_pkg::ces_req_t      req_type_i [LANES],
   input  wire ces_pkg::ces_line_t     req_state_i [LANES],
   // Counter result
   output logic [CNT_WIDTH-1:0]        count_o,
   output logic [$clog2(LANES+1)-1:0]  hits_o
);

   localparam int HW = $clog2(LANES + 1);

   // Counter may not be narrower than one cycle's hits, nor wider than its reset constant
   if (LANES < 1 || CNT_WIDTH < HW || CNT_WIDTH > $bits(ces_pkg::CNT_RESET))
   begin : g_param_check
      $error("ces_event_selector: unsupported parameters");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Qualification

   logic [LANES-1:0] match;

   function automatic logic lane_match(input logic [7:0] ev, input logic [7:0] um,
                                       input ces_pkg::ces_req_t t, input ces_pkg::ces_line_t s);
      logic [3:0] st;
      logic       lo_cls;
      logic       hi_cls;
      logic       res;
      st     = 4'h0;
      lo_cls = 1'b0;
      hi_cls = 1'b0;
      res    = 1'b0;
      st[s]  = 1'b1;
      case (ev)
         ces_pkg::EVT_ALL_REQ:
         begin
            res = (um == ces_pkg::UM_ALL) && (t != ces_pkg::CES_REQ_OTHER);
         end
         ces_pkg::EVT_DATA_REQ:
         begin
            lo_cls = (t == ces_pkg::CES_REQ_DEMAND_LOAD) || (t == ces_pkg::CES_REQ_L1_PREFETCH);
            hi_cls = (t == ces_pkg::CES_REQ_PREFETCH) || (t == ces_pkg::CES_REQ_PREF_RFO);
            // Prefetch RFO cannot own a shared line, so it is seen as a miss
            if (t == ces_pkg::CES_REQ_PREF_RFO && s == ces_pkg::CES_LINE_S)
            begin
               st = 4'h1;
            end
            res = (lo_cls && |(um[3:0] & st))
               || (hi_cls && |(um[7:ces_pkg::UM_HI_OFS] & st));
         end
         ces_pkg::EVT_WRITE_REQ:
         begin
            lo_cls = (t == ces_pkg::CES_REQ_STORE_RFO);
            hi_cls = (t == ces_pkg::CES_REQ_LOCK_RFO);
            res = (lo_cls && |(um[3:0] & st))
               || (hi_cls && |(um[7:ces_pkg::UM_HI_OFS] & st));
         end
         default:
         begin
            res = 1'b0;
         end
      endcase
      return res;
   endfunction

   always_comb
   begin
      for (int i = 0; i < LANES; i++)
      begin
         match[i] = req_valid_i[i] && lane_match(event_sel_i, unit_mask_i, req_type_i[i], req_state_i[i]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter

   logic [HW-1:0]        hits_d;
   logic [HW-1:0]        hits_q;
   logic [CNT_WIDTH-1:0] count_d;
   logic [CNT_WIDTH-1:0] count_q;

   always_comb
   begin
      hits_d = '0;
      for (int i = 0; i < LANES; i++)
      begin
         hits_d = hits_d + HW'(match[i]);
      end
      // Disabled counter holds; wraps silently since overflow is handled elsewhere
      count_d = count_q + (count_en_i ? CNT_WIDTH'(hits_d) : '0);
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         count_q <= ces_pkg::CNT_RESET[CNT_WIDTH-1:0];
         hits_q  <= '0;
      end
      else
      begin
         count_q <= count_d;
         hits_q  <= hits_d;
      end
   end

   assign count_o = count_q;
   assign hits_o  = hits_q;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   // The reset edge itself clears the count, so a cycle sampled in reset starts no check
   property p_count_step;
      @(posedge ref_clk_i) disable iff (rst_i)
      (!rst_i && count_en_i) |=> count_q == $past(count_q) + CNT_WIDTH'(hits_q);
   endproperty
   a_count_step: assert property (p_count_step) else $error("count step wrong");

   property p_count_hold;
      @(posedge ref_clk_i) disable iff (rst_i)
      (!rst_i && (!count_en_i || hits_d == '0)) |=> $stable(count_q);
   endproperty
   a_count_hold: assert property (p_count_hold) else $error("count moved");

   property p_all_req;
      @(posedge ref_clk_i) disable iff (rst_i)
      (event_sel_i == 8'h24 && unit_mask_i == 8'hFF && req_valid_i[0]
       && req_type_i[0] != ces_pkg::CES_REQ_OTHER) |-> match[0];
   endproperty
   a_all_req: assert property (p_all_req) else $error("all request miss");

   property p_demand_any;
      @(posedge ref_clk_i) disable iff (rst_i)
      (event_sel_i == 8'h26 && unit_mask_i[3:0] == 4'hF && req_valid_i[0]
       && (req_type_i[0] == ces_pkg::CES_REQ_DEMAND_LOAD || req_type_i[0] == ces_pkg::CES_REQ_L1_PREFETCH))
      |-> match[0];
   endproperty
   a_demand_any: assert property (p_demand_any) else $error("demand load lost");

   property p_demand_state;
      @(posedge ref_clk_i) disable iff (rst_i)
      (event_sel_i == 8'h26 && unit_mask_i == 8'h01 && req_valid_i[0]
       && req_type_i[0] == ces_pkg::CES_REQ_DEMAND_LOAD)
      |-> match[0] == (req_state_i[0] == ces_pkg::CES_LINE_I);
   endproperty
   a_demand_state: assert property (p_demand_state) else $error("demand state wrong");

   property p_pref_rfo_shared;
      @(posedge ref_clk_i) disable iff (rst_i)
      (event_sel_i == 8'h26 && unit_mask_i == 8'h20 && req_valid_i[0]
       && req_type_i[0] == ces_pkg::CES_REQ_PREF_RFO) |-> !match[0];
   endproperty
   a_pref_rfo_shared: assert property (p_pref_rfo_shared) else $error("prefetch rfo hit shared");

   property p_rfo_hit;
      @(posedge ref_clk_i) disable iff (rst_i)
      (event_sel_i == 8'h27 && unit_mask_i == 8'h0E && req_valid_i[0]
       && req_type_i[0] == ces_pkg::CES_REQ_STORE_RFO)
      |-> match[0] == (req_state_i[0] != ces_pkg::CES_LINE_I);
   endproperty
   a_rfo_hit: assert property (p_rfo_hit) else $error("rfo hit wrong");

   property p_lock_only;
      @(posedge ref_clk_i) disable iff (rst_i)
      (event_sel_i == 8'h27 && unit_mask_i == 8'hF0 && req_valid_i[0])
      |-> match[0] == (req_type_i[0] == ces_pkg::CES_REQ_LOCK_RFO);
   endproperty
   a_lock_only: assert property (p_lock_only) else $error("lock class wrong");

   property p_rfo_demand_only;
      @(posedge ref_clk_i) disable iff (rst_i)
      (event_sel_i == 8'h27 && unit_mask_i == 8'h0F && req_valid_i[0]
       && req_type_i[0] == ces_pkg::CES_REQ_PREF_RFO) |-> !match[0];
   endproperty
   a_rfo_demand_only: assert property (p_rfo_demand_only) else $error("prefetch rfo counted");

   property p_pref_state;
      @(posedge ref_clk_i) disable iff (rst_i)
      (event_sel_i == ces_pkg::EVT_DATA_REQ && unit_mask_i == 8'h40 && req_valid_i[0]
       && req_type_i[0] == ces_pkg::CES_REQ_PREFETCH)
      |-> match[0] == (req_state_i[0] == ces_pkg::CES_LINE_E);
   endproperty
   a_pref_state: assert property (p_pref_state) else $error("prefetch state wrong");

   property p_rfo_state;
      @(posedge ref_clk_i) disable iff (rst_i)
      (event_sel_i == ces_pkg::EVT_WRITE_REQ && unit_mask_i == 8'h08 && req_valid_i[0]
       && req_type_i[0] == ces_pkg::CES_REQ_STORE_RFO)
      |-> match[0] == (req_state_i[0] == ces_pkg::CES_LINE_M);
   endproperty
   a_rfo_state: assert property (p_rfo_state) else $error("rfo state wrong");

   property p_data_any;
      @(posedge ref_clk_i) disable iff (rst_i)
      (event_sel_i == ces_pkg::EVT_DATA_REQ && unit_mask_i == ces_pkg::UM_ALL && req_valid_i[0])
      |-> match[0] == (req_type_i[0] inside {ces_pkg::CES_REQ_DEMAND_LOAD, ces_pkg::CES_REQ_L1_PREFETCH,
                                              ces_pkg::CES_REQ_PREFETCH, ces_pkg::CES_REQ_PREF_RFO});
   endproperty
   a_data_any: assert property (p_data_any) else $error("data request class wrong");

   property p_rfo_any;
      @(posedge ref_clk_i) disable iff (rst_i)
      (event_sel_i == ces_pkg::EVT_WRITE_REQ && unit_mask_i == 8'h0F && req_valid_i[0])
      |-> match[0] == (req_type_i[0] == ces_pkg::CES_REQ_STORE_RFO);
   endproperty
   a_rfo_any: assert property (p_rfo_any) else $error("store rfo class wrong");

   c_all_req:  cover property (@(posedge ref_clk_i) disable iff (rst_i)
                  event_sel_i == 8'h24 && hits_d != '0);
   c_data_any: cover property (@(posedge ref_clk_i) disable iff (rst_i)
                  event_sel_i == 8'h26 && unit_mask_i == 8'hFF && hits_d == HW'(LANES));
   c_lock:     cover property (@(posedge ref_clk_i) disable iff (rst_i)
                  event_sel_i == 8'h27 && unit_mask_i[7:4] != 4'h0 && hits_d != '0);

endmodule

/* File: ces_pipe_model.sv */
`timescale 1ns/1ns
module ces_pipe_model (
   // Requests toward the selector
   output logic [1:0]         valid_o,
   output ces_pkg::ces_req_t  type_o [2],
   output ces_pkg::ces_line_t state_o [2]
);
   initial
   begin
      valid_o = 2'b00;
      type_o  = '{default: ces_pkg::CES_REQ_OTHER};
      state_o = '{default: ces_pkg::CES_LINE_I};
   end
   // Called at a rising edge; an idle lane shows inverted fields so stale values never match
   task automatic put(input logic [1:0] v, input logic [2:0] t0, t1, input logic [1:0] s0, s1);
      valid_o    <= v;
      type_o[0]  <= ces_pkg::ces_req_t'(v[0] ? t0 : ~t0);
      type_o[1]  <= ces_pkg::ces_req_t'(v[1] ? t1 : ~t1);
      state_o[0] <= ces_pkg::ces_line_t'(v[0] ? s0 : ~s0);
      state_o[1] <= ces_pkg::ces_line_t'(v[1] ? s1 : ~s1);
   endtask
endmodule

/* File: ces_pkg.sv */
package ces_pkg;

   // Event numbers
   localparam logic [7:0] EVT_ALL_REQ    = 8'h24;
   localparam logic [7:0] EVT_DATA_REQ   = 8'h26;
   localparam logic [7:0] EVT_WRITE_REQ  = 8'h27;

   // Unit mask field positions: low nibble = first class, high nibble = second class
   localparam int         UM_I_BIT       = 0;
   localparam int         UM_S_BIT       = 1;
   localparam int         UM_E_BIT       = 2;
   localparam int         UM_M_BIT       = 3;
   localparam int         UM_HI_OFS      = 4;
   localparam logic [7:0] UM_ALL         = 8'hFF;

   // Line coherence state encoding
   typedef enum logic [1:0] {
      CES_LINE_I = 2'h0,
      CES_LINE_S = 2'h1,
      CES_LINE_E = 2'h2,
      CES_LINE_M = 2'h3
   } ces_line_t;

   // Request class encoding
   typedef enum logic [2:0] {
      CES_REQ_DEMAND_LOAD = 3'h0,
      CES_REQ_L1_PREFETCH = 3'h1,
      CES_REQ_PREFETCH    = 3'h2,
      CES_REQ_STORE_RFO   = 3'h3,
      CES_REQ_LOCK_RFO    = 3'h4,
      CES_REQ_PREF_RFO    = 3'h5,
      CES_REQ_IFETCH      = 3'h6,
      CES_REQ_OTHER       = 3'h7
   } ces_req_t;

   localparam logic [47:0] CNT_RESET     = 48'h0000_0000_0000;

endpackage

/* File: tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   logic               ref_clk_i   = 1'b0;
   logic               rst_i       = 1'b1;
   logic [7:0]         event_sel_i = 8'h00;
   logic [7:0]         unit_mask_i = 8'h00;
   logic               count_en_i  = 1'b1;
   logic [1:0]         req_valid_i;
   ces_pkg::ces_req_t  req_type_i [2];
   ces_pkg::ces_line_t req_state_i [2];
   logic [47:0]        count_o;
   logic [1:0]         hits_o;
   logic [47:0]        exp_cnt     = 48'h0000_0000_0000;
   int                 n_errors    = 0;
   int                 num_checks  = 0;

   always #20 ref_clk_i = ~ref_clk_i;

   ces_pipe_model ces_pipe_model_i (.valid_o(req_valid_i), .type_o(req_type_i), .state_o(req_state_i));
   ces_event_selector ces_event_selector_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .event_sel_i(event_sel_i),
      .unit_mask_i(unit_mask_i), .count_en_i(count_en_i), .req_valid_i(req_valid_i),
      .req_type_i(req_type_i), .req_state_i(req_state_i), .count_o(count_o), .hits_o(hits_o));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic match(input logic [7:0] ev, um, input logic [2:0] t, input logic [1:0] s);
      logic [1:0] sp;
      sp = (t == 3'h5 && s == 2'h1) ? 2'h0 : s;
      case (ev)
         8'h24: return um == 8'hFF && t != 3'h7;
         8'h26: return (t < 3'h2 && um[sp]) || ((t == 3'h2 || t == 3'h5) && um[4 + sp]);
         8'h27: return (t == 3'h3 && um[s]) || (t == 3'h4 && um[4 + s]);
         default: return 1'b0;
      endcase
   endfunction

   task automatic chk(input logic [47:0] seen, want);
      num_checks++;
      if (seen !== want)
      begin
         n_errors++;
         $display("FAIL %0t: got %0h want %0h", $time, seen, want);
      end
   endtask

   task automatic wrap_up();
      $display("Checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // One request cycle; valid drops at the answering edge so nothing is counted twice
   task automatic step(input logic [7:0] ev, um, input logic [1:0] v, input logic [2:0] t0, t1,
                       input logic [1:0] s0, s1);
      logic [1:0] n;
      n = 2'(v[0] & match(ev, um, t0, s0)) + 2'(v[1] & match(ev, um, t1, s1));
      @(posedge ref_clk_i);
      event_sel_i <= ev;
      unit_mask_i <= um;
      ces_pipe_model_i.put(v, t0, t1, s0, s1);
      @(posedge ref_clk_i);
      ces_pipe_model_i.put(2'b00, t0, t1, s0, s1);
      #1;
      if (count_en_i)
         exp_cnt += 48'(n);
      chk(48'(hits_o), 48'(n));
      chk(count_o, exp_cnt);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Every event incl. an unknown one, each mask, each type against at least three of the four states
   task automatic t_select();
      logic [7:0] evs [4] = '{8'h24, 8'h26, 8'h27, 8'h25};
      logic [7:0] ms [13] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h0F, 8'hF0,
                              8'hFF, 8'h0E, 8'h00};
      foreach (evs[e])
         foreach (ms[m])
            for (int k = 0; k < 32; k++)
               step(evs[e], ms[m], 2'(1 + k % 3), 3'(k / 4), 3'(7 - k / 4), 2'(k), 2'(k + 1));
   endtask

   // Disabled counter still reports hits but holds its value
   task automatic t_hold();
      @(posedge ref_clk_i);
      count_en_i <= 1'b0;
      step(8'h26, 8'hFF, 2'b11, 3'h0, 3'h2, 2'h1, 2'h3);
      @(posedge ref_clk_i);
      count_en_i <= 1'b1;
   endtask

   // Reset in mid-run clears a non-zero count
   task automatic t_reset();
      step(8'h24, 8'hFF, 2'b11, 3'h6, 3'h0, 2'h0, 2'h2);
      @(posedge ref_clk_i);
      rst_i <= 1'b1;
      @(posedge ref_clk_i);
      rst_i <= 1'b0;
      #1;
      exp_cnt = 48'h0000_0000_0000;
      chk(count_o, exp_cnt);
      chk(48'(hits_o), 48'h0000_0000_0000);
   endtask

   initial
   begin
      repeat (12) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      t_select();
      t_hold();
      t_reset();
      t_hold();
      wrap_up();
   end

   // Run needs about 3400 cycles
   initial
   begin
      #(10000 * 40);
      n_errors++;
      wrap_up();
   end
endmodule
